//--- core/psu_seq_pkg.sv
// Shared constants and types of the power supply signal sequencer
package psu_seq_pkg;
	// Clock and timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
	localparam int BLINK_MS_DEF = 500;
	localparam logic [2:0] LAST_SLOT = 3'h5;
	localparam int MS_W = 11;

	// Times in ms; limits as specified, targets chosen inside them
	localparam int LG_ON_START_MAX_MS = 2000;
	localparam int LG_ON_START_MS = 1000;
	localparam int LG_ON_DIP_MAX_MS = 100;
	localparam int LG_ON_DIP_MS = 50;
	localparam int LG_TO_MAIN_MIN_MS = 7;
	localparam int LG_TO_STBY_MIN_MS = 15;
	localparam int STBY_TO_MAIN_MIN_MS = 10;
	localparam int STBY_TO_MAIN_MAX_MS = 500;
	localparam int OFF_MIN_MS = 1000;
	localparam int OFF_MAX_MS = 1200;
	localparam int EN_DELAY_MIN_MS = 2;
	localparam int EN_DELAY_MAX_MS = 20;
	localparam int EN_DELAY_MS = 5;

	// Same times as counts of 1 ms ticks
	localparam logic [MS_W-1:0] LG_ON_START_CNT = MS_W'(LG_ON_START_MS);
	localparam logic [MS_W-1:0] LG_ON_DIP_CNT = MS_W'(LG_ON_DIP_MS);
	localparam logic [MS_W-1:0] LG_TO_MAIN_CNT = MS_W'(LG_TO_MAIN_MIN_MS);
	localparam logic [MS_W-1:0] LG_TO_STBY_CNT = MS_W'(LG_TO_STBY_MIN_MS);
	localparam logic [MS_W-1:0] STBY_TO_MAIN_CNT = MS_W'(STBY_TO_MAIN_MIN_MS);
	localparam logic [MS_W-1:0] OFF_MIN_CNT = MS_W'(OFF_MIN_MS);
	localparam logic [MS_W-1:0] EN_DELAY_CNT = MS_W'(EN_DELAY_MS);

	// Fan error thresholds in percent
	localparam logic [6:0] FAN_MAJOR_PCT = 7'h0F;
	localparam logic [6:0] FAN_MINOR_PCT = 7'h05;

	// Register port
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	localparam int CTRL_IDLE_BIT = 0;
	localparam logic CTRL_IDLE_RST = 1'h0;
	localparam int ST_STBY_BIT = 0;
	localparam int ST_MAIN_BIT = 1;
	localparam int ST_LG_BIT = 2;
	localparam int ST_LATCH_BIT = 3;
	localparam int ST_IDLE_BIT = 4;
	localparam int ST_ENREQ_BIT = 5;
	localparam int ST_PAT_LSB = 8;

	typedef enum logic [1:0] {
		STBY_HOLD = 2'h0,
		STBY_READY = 2'h1,
		STBY_ON = 2'h2
	} stby_e;

	typedef enum logic [1:0] {
		MAIN_HOLD = 2'h0,
		MAIN_READY = 2'h1,
		MAIN_ON = 2'h2
	} main_e;

	typedef enum logic [2:0] {
		PAT_OFF = 3'h0,
		PAT_GREEN = 3'h1,
		PAT_EN_OFF = 3'h2,
		PAT_IDLE = 3'h3,
		PAT_FAULT = 3'h4,
		PAT_OT_WARN = 3'h5,
		PAT_FAN_MINOR = 3'h6
	} pat_e;
endpackage

//--- core/psu_blink_timebase.sv
// Millisecond tick and blink slot generator
`timescale 1ns/10ps
module psu_blink_timebase #(
	parameter int CYC_PER_MS = psu_seq_pkg::CYC_PER_MS,
	parameter int BLINK_MS = psu_seq_pkg::BLINK_MS_DEF
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	output logic tick_o, // One-cycle pulse every ms
	output logic [2:0] slot_o // Blink slot, 0 to 5
);
	localparam int CW = $clog2(CYC_PER_MS);
	localparam int BW = $clog2(BLINK_MS + 1);
	localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
	localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_MS - 1);

	if (CYC_PER_MS < 2 || BLINK_MS < 1) begin : g_bad
		$error("timebase parameters out of range");
	end

	logic [CW-1:0] cyc;
	logic [BW-1:0] bms;
	wire cyc_end = cyc == CYC_LAST;
	wire blink_end = cyc_end && (bms == BLINK_LAST);
	wire slot_end = slot_o == psu_seq_pkg::LAST_SLOT;

	// Six slots so that both 1:1 and 1:2 patterns repeat cleanly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc <= '0;
			bms <= '0;
			tick_o <= 1'h0;
			slot_o <= 3'h0;
		end else begin
			cyc <= cyc_end ? '0 : cyc + 1'h1;
			tick_o <= cyc_end;
			if (cyc_end) begin
				bms <= (bms == BLINK_LAST) ? '0 : bms + 1'h1;
			end
			if (blink_end) begin
				slot_o <= slot_end ? 3'h0 : slot_o + 3'h1;
			end
		end
	end
endmodule

//--- core/psu_signal_sequencer.sv
// Rail sequencing, line-good timing and status LEDs of a power supply
// Overview of operation
// - Line LED green while line in range
// - DC LED blinks per enable and idle
// - Listed faults show solid yellow DC LED
// - Warnings blink yellow/green 2:1 or 1:1
// - DC LED conditions tested in fixed priority
// - Kill input high disables main rail
// - Standby rail ignores the kill input
// - Start automatically with line and enable
// - Line good within start-up or dip delay
// - Line good drops within 5 ms
// - Main rail 10 to 500 ms after standby
// - Line good leads rail drops by margins
// - Rails stay off 1000 to 1200 ms
// - Main rail follows the enable input
// - Enable toggle clears latched faults
// - Main rail reacts 2 to 20 ms after enable
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module psu_signal_sequencer #(
	parameter int CYC_PER_MS = psu_seq_pkg::CYC_PER_MS,
	parameter int BLINK_MS = psu_seq_pkg::BLINK_MS_DEF
) (
	input wire logic CLK_I, // 100 MHz clock
	input wire logic RST_I, // Synchronous reset, high
	input wire logic LINE_OK_I, // Input line within range
	input wire logic MAIN_OUTPUT_ENABLE_N_I, // Main enable, low active
	input wire logic HOT_UNPLUG_KILL_I, // Unplug kill, high active
	input wire logic IDLE_STANDBY_PERMIT_I, // Idle standby permit pin
	input wire logic LIGHT_LOAD_I, // Load low enough for idle
	input wire logic MAIN_REG_OK_I, // Main rail in regulation
	input wire logic STBY_REG_OK_I, // Standby rail in regulation
	input wire logic OT_SHUT_I, // Overtemperature shutdown
	input wire logic OT_WARN_I, // Overtemperature warning
	input wire logic OV_I, // Overvoltage trip, either rail
	input wire logic OC_I, // Overcurrent trip, either rail
	input wire logic [6:0] FAN_ERR_PCT_I, // Fan error in percent
	input wire logic [3:0] ADDR_I, // Register address
	input wire logic [31:0] WDATA_I, // Register write data
	input wire logic WE_I, // Write strobe
	input wire logic RE_I, // Read strobe
	output logic [31:0] RDATA_O, // Read data, cycle after strobe
	output logic STBY_RAIL_EN_O, // Standby rail enable
	output logic MAIN_RAIL_EN_O, // Main rail enable
	output logic LINE_GOOD_O, // Line good, high active
	output logic LINE_LED_O, // Line LED green
	output logic DC_GREEN_O, // DC LED green
	output logic DC_YELLOW_O // DC LED yellow
);
	localparam int MS_W = psu_seq_pkg::MS_W;
	localparam int NPIN = 18;
	// Enable input idles high like its pull-up
	localparam logic [NPIN-1:0] PIN_RST = 18'h00002;

	if (psu_seq_pkg::EN_DELAY_MS < psu_seq_pkg::EN_DELAY_MIN_MS ||
			psu_seq_pkg::EN_DELAY_MS >= psu_seq_pkg::EN_DELAY_MAX_MS ||
			psu_seq_pkg::LG_ON_START_MS >= psu_seq_pkg::LG_ON_START_MAX_MS ||
			psu_seq_pkg::LG_ON_DIP_MS >= psu_seq_pkg::LG_ON_DIP_MAX_MS ||
			psu_seq_pkg::LG_TO_MAIN_MIN_MS >= psu_seq_pkg::LG_TO_STBY_MIN_MS) begin : g_bad
		$error("sequencer timing constants out of range");
	end

	function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'h1;
	endfunction

	// Two-flop synchronisers for every pin
	logic [NPIN-1:0] pin_meta;
	logic [NPIN-1:0] pin_s;
	wire [NPIN-1:0] pin_raw = {FAN_ERR_PCT_I, OC_I, OV_I, OT_WARN_I, OT_SHUT_I,
		STBY_REG_OK_I, MAIN_REG_OK_I, LIGHT_LOAD_I, IDLE_STANDBY_PERMIT_I,
		HOT_UNPLUG_KILL_I, MAIN_OUTPUT_ENABLE_N_I, LINE_OK_I};

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pin_meta <= PIN_RST;
			pin_s <= PIN_RST;
		end else begin
			pin_meta <= pin_raw;
			pin_s <= pin_meta;
		end
	end

	wire line_ok = pin_s[0];
	wire en_n_s = pin_s[1];
	wire kill = pin_s[2];
	wire idle_pin = pin_s[3];
	wire light_load = pin_s[4];
	wire main_reg_ok = pin_s[5];
	wire stby_reg_ok = pin_s[6];
	wire ot_shut = pin_s[7];
	wire ot_warn = pin_s[8];
	wire ov = pin_s[9];
	wire oc = pin_s[10];
	// Fan value changes slowly; a torn sample lasts one cycle at most
	wire [6:0] fan_pct = pin_s[17:11];

	logic tick;
	logic [2:0] slot;

	psu_blink_timebase #(
		.CYC_PER_MS(CYC_PER_MS),
		.BLINK_MS(BLINK_MS)
	) u_timebase (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.tick_o(tick),
		.slot_o(slot)
	);

	// Enable filter: a new level must persist before the rail follows
	logic en_req;
	logic [MS_W-1:0] en_ms;
	wire en_diff = en_n_s == en_req;
	wire en_flip = en_diff && (en_ms == psu_seq_pkg::EN_DELAY_CNT);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			en_req <= 1'h0;
			en_ms <= '0;
		end else if (!en_diff || en_flip) begin
			en_req <= en_flip ? !en_req : en_req;
			en_ms <= '0;
		end else if (tick) begin
			en_ms <= sat_inc(en_ms);
		end
	end

	// Latched shutdown faults; a new trip wins over the clear
	logic flt_latch;
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			flt_latch <= 1'h0;
		end else begin
			flt_latch <= ov || oc || (flt_latch && en_req);
		end
	end

	// Software control register
	logic ctrl_idle;
	wire ctrl_wr = WE_I && (ADDR_I == psu_seq_pkg::CTRL_OFS);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ctrl_idle <= psu_seq_pkg::CTRL_IDLE_RST;
		end else if (ctrl_wr) begin
			ctrl_idle <= WDATA_I[psu_seq_pkg::CTRL_IDLE_BIT];
		end
	end

	wire idle = ctrl_idle && idle_pin && light_load && en_req && !flt_latch && !ot_shut;

	// Line good and the line-loss timer that orders the rail drops
	logic lg;
	logic started;
	logic [MS_W-1:0] lg_ms;
	logic [MS_W-1:0] lost_ms;
	wire [MS_W-1:0] lg_target = started ? psu_seq_pkg::LG_ON_DIP_CNT :
		psu_seq_pkg::LG_ON_START_CNT;
	wire main_drop = lost_ms > psu_seq_pkg::LG_TO_MAIN_CNT;
	wire stby_drop = lost_ms > psu_seq_pkg::LG_TO_STBY_CNT;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			lg <= 1'h0;
			started <= 1'h0;
			lg_ms <= '0;
			lost_ms <= '0;
		end else if (!line_ok) begin
			lg <= 1'h0;
			lg_ms <= '0;
			if (tick && !lg) begin
				lost_ms <= sat_inc(lost_ms);
			end
		end else begin
			lost_ms <= '0;
			if (!lg && lg_ms >= lg_target) begin
				lg <= 1'h1;
				started <= 1'h1;
			end else if (tick && !lg) begin
				lg_ms <= sat_inc(lg_ms);
			end
		end
	end

	// Standby rail
	psu_seq_pkg::stby_e stby_st;
	psu_seq_pkg::stby_e next_stby_st;
	logic [MS_W-1:0] stby_off_ms;
	logic [MS_W-1:0] stby_up_ms;
	wire stby_on = stby_st == psu_seq_pkg::STBY_ON;

	// Kill input deliberately absent here
	always_comb begin
		next_stby_st = stby_st;
		unique case (stby_st)
			psu_seq_pkg::STBY_HOLD: begin
				if (stby_off_ms > psu_seq_pkg::OFF_MIN_CNT) begin
					next_stby_st = psu_seq_pkg::STBY_READY;
				end
			end
			psu_seq_pkg::STBY_READY: begin
				if (line_ok) begin
					next_stby_st = psu_seq_pkg::STBY_ON;
				end
			end
			psu_seq_pkg::STBY_ON: begin
				if (stby_drop) begin
					next_stby_st = psu_seq_pkg::STBY_HOLD;
				end
			end
			default: next_stby_st = psu_seq_pkg::STBY_HOLD;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			stby_st <= psu_seq_pkg::STBY_READY;
			stby_off_ms <= '0;
			stby_up_ms <= '0;
		end else begin
			stby_st <= next_stby_st;
			if (stby_st != psu_seq_pkg::STBY_HOLD) begin
				stby_off_ms <= '0;
			end else if (tick) begin
				stby_off_ms <= sat_inc(stby_off_ms);
			end
			if (!stby_on) begin
				stby_up_ms <= '0;
			end else if (tick) begin
				stby_up_ms <= sat_inc(stby_up_ms);
			end
		end
	end

	// Main rail
	psu_seq_pkg::main_e main_st;
	psu_seq_pkg::main_e next_main_st;
	logic [MS_W-1:0] main_off_ms;
	wire stby_settled = stby_on && (stby_up_ms > psu_seq_pkg::STBY_TO_MAIN_CNT);
	wire main_go = line_ok && en_req && !kill && !flt_latch && !ot_shut &&
		!idle && stby_settled;
	wire main_stop = kill || !en_req || flt_latch || ot_shut || idle ||
		main_drop || !stby_on;

	always_comb begin
		next_main_st = main_st;
		unique case (main_st)
			psu_seq_pkg::MAIN_HOLD: begin
				if (main_off_ms > psu_seq_pkg::OFF_MIN_CNT) begin
					next_main_st = psu_seq_pkg::MAIN_READY;
				end
			end
			psu_seq_pkg::MAIN_READY: begin
				if (main_go) begin
					next_main_st = psu_seq_pkg::MAIN_ON;
				end
			end
			psu_seq_pkg::MAIN_ON: begin
				if (main_stop) begin
					next_main_st = psu_seq_pkg::MAIN_HOLD;
				end
			end
			default: next_main_st = psu_seq_pkg::MAIN_HOLD;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			main_st <= psu_seq_pkg::MAIN_READY;
			main_off_ms <= '0;
		end else begin
			main_st <= next_main_st;
			if (main_st != psu_seq_pkg::MAIN_HOLD) begin
				main_off_ms <= '0;
			end else if (tick) begin
				main_off_ms <= sat_inc(main_off_ms);
			end
		end
	end

	// DC LED pattern selection
	wire main_on = main_st == psu_seq_pkg::MAIN_ON;
	wire rail_bad = (main_on && !main_reg_ok) || (stby_on && !stby_reg_ok);
	wire solid_fault = rail_bad || ot_shut || flt_latch ||
		(fan_pct > psu_seq_pkg::FAN_MAJOR_PCT);
	wire fan_minor = (fan_pct > psu_seq_pkg::FAN_MINOR_PCT) &&
		(fan_pct < psu_seq_pkg::FAN_MAJOR_PCT);
	wire healthy = main_on && stby_on && main_reg_ok && stby_reg_ok;
	psu_seq_pkg::pat_e pat;
	psu_seq_pkg::pat_e next_pat;

	// First true condition wins
	assign next_pat = en_n_s ? psu_seq_pkg::PAT_EN_OFF :
		idle ? psu_seq_pkg::PAT_IDLE :
		solid_fault ? psu_seq_pkg::PAT_FAULT :
		ot_warn ? psu_seq_pkg::PAT_OT_WARN :
		fan_minor ? psu_seq_pkg::PAT_FAN_MINOR :
		healthy ? psu_seq_pkg::PAT_GREEN : psu_seq_pkg::PAT_OFF;

	wire [2:0] slot_m3 = (slot >= 3'h3) ? slot - 3'h3 : slot;
	wire even = !slot[0];
	logic next_yel;
	logic next_grn;

	always_comb begin
		next_yel = 1'h0;
		next_grn = 1'h0;
		unique case (pat)
			psu_seq_pkg::PAT_OFF: ;
			psu_seq_pkg::PAT_GREEN: next_grn = 1'h1;
			psu_seq_pkg::PAT_EN_OFF: next_yel = even;
			psu_seq_pkg::PAT_IDLE: begin
				next_yel = slot_m3 == 3'h0;
				next_grn = slot_m3 != 3'h0;
			end
			psu_seq_pkg::PAT_FAULT: next_yel = 1'h1;
			psu_seq_pkg::PAT_OT_WARN: begin
				next_yel = slot_m3 != 3'h2;
				next_grn = slot_m3 == 3'h2;
			end
			psu_seq_pkg::PAT_FAN_MINOR: begin
				next_yel = even;
				next_grn = !even;
			end
			default: ;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pat <= psu_seq_pkg::PAT_OFF;
			DC_YELLOW_O <= 1'h0;
			DC_GREEN_O <= 1'h0;
			LINE_LED_O <= 1'h0;
		end else begin
			pat <= next_pat;
			DC_YELLOW_O <= next_yel;
			DC_GREEN_O <= next_grn;
			LINE_LED_O <= line_ok;
		end
	end

	assign STBY_RAIL_EN_O = stby_on;
	assign MAIN_RAIL_EN_O = main_on;
	assign LINE_GOOD_O = lg;

	// Register read port; unmapped addresses read zero
	wire [31:0] stat_word = {21'h000000, pat, 2'h0, en_req, idle, flt_latch, lg,
		main_on, stby_on};
	wire [31:0] ctrl_word = {31'h00000000, ctrl_idle};
	wire [31:0] next_rdata = (ADDR_I == psu_seq_pkg::CTRL_OFS) ? ctrl_word :
		(ADDR_I == psu_seq_pkg::STAT_OFS) ? stat_word : 32'h00000000;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			RDATA_O <= 32'h00000000;
		end else begin
			RDATA_O <= RE_I ? next_rdata : 32'h00000000;
		end
	end

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	property p_line_led;
		$changed(line_ok) |=> LINE_LED_O == $past(line_ok);
	endproperty
	a_line_led: assert property (p_line_led) else $error("line LED wrong");

	property p_kill;
		kill |=> !MAIN_RAIL_EN_O;
	endproperty
	a_kill: assert property (p_kill) else $error("main on under kill");

	property p_stby_kill;
		STBY_RAIL_EN_O && kill && !stby_drop |=> STBY_RAIL_EN_O;
	endproperty
	a_stby_kill: assert property (p_stby_kill) else $error("standby hit by kill");

	property p_lg_off;
		!line_ok |=> !LINE_GOOD_O;
	endproperty
	a_lg_off: assert property (p_lg_off) else $error("line good late off");

	property p_main_after_stby;
		$rose(MAIN_RAIL_EN_O) |-> STBY_RAIL_EN_O &&
			$past(stby_up_ms) > psu_seq_pkg::STBY_TO_MAIN_CNT;
	endproperty
	a_main_after_stby: assert property (p_main_after_stby) else $error("main too early");

	property p_stby_drop;
		$fell(STBY_RAIL_EN_O) |-> !LINE_GOOD_O &&
			$past(lost_ms) > psu_seq_pkg::LG_TO_STBY_CNT;
	endproperty
	a_stby_drop: assert property (p_stby_drop) else $error("standby drop early");

	property p_off_hold;
		main_st == psu_seq_pkg::MAIN_HOLD && main_off_ms <= psu_seq_pkg::OFF_MIN_CNT
			|=> !MAIN_RAIL_EN_O;
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("main off time short");

	property p_main_en;
		$rose(MAIN_RAIL_EN_O) |-> $past(en_req) && !$past(en_n_s);
	endproperty
	a_main_en: assert property (p_main_en) else $error("main on without enable");

	property p_clear;
		!en_req && !ov && !oc |=> !flt_latch;
	endproperty
	a_clear: assert property (p_clear) else $error("fault not cleared");

	property p_en_delay;
		$changed(en_req) |-> $past(en_ms) == psu_seq_pkg::EN_DELAY_CNT;
	endproperty
	a_en_delay: assert property (p_en_delay) else $error("enable delay wrong");

	property p_prio;
		en_n_s |=> (pat == psu_seq_pkg::PAT_EN_OFF) ##1 !DC_GREEN_O;
	endproperty
	a_prio: assert property (p_prio) else $error("enable pattern lost");

	property p_fault;
		!en_n_s && !idle && solid_fault |=> ##1 (DC_YELLOW_O && !DC_GREEN_O);
	endproperty
	a_fault: assert property (p_fault) else $error("fault not solid yellow");

	c_main_on: cover property ($rose(MAIN_RAIL_EN_O));
	c_lg_on: cover property ($rose(LINE_GOOD_O));
	c_idle: cover property (pat == psu_seq_pkg::PAT_IDLE);
	c_kill: cover property (MAIN_RAIL_EN_O && kill);
endmodule

//--- sim/psu_host_model.sv
// Host side model that drives the enable and kill pins
`timescale 1ns/10ps
module psu_host_model #(
	parameter int MIN_HIGH_CYC = 40
) (
	input wire logic clk_i, // Bench clock
	input wire logic rst_i, // Synchronous reset
	input wire logic want_on_i, // Bench asks for main output
	input wire logic seated_i, // Module fully inserted
	output logic enable_n_o, // Main enable pin, low active
	output logic kill_o, // Unplug kill pin, high active
	output logic inserted_o // Host view of presence
);
	logic [15:0] high_cnt;
	logic present_n;
	assign present_n = ~seated_i;
	assign inserted_o = ~present_n;
	// Recessed kill pin opens first on withdrawal
	assign kill_o = ~seated_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_n_o <= 1'b1;
			high_cnt <= '0;
		end else if (enable_n_o) begin
			if (high_cnt < 16'(MIN_HIGH_CYC)) begin
				high_cnt <= high_cnt + 16'h0001;
			end else if (want_on_i) begin
				enable_n_o <= 1'b0;
			end
		end else if (!want_on_i) begin
			enable_n_o <= 1'b1;
			high_cnt <= '0;
		end
	end
endmodule

//--- sim/psu_signal_sequencer_test.sv
// Self-checking bench of the power supply signal sequencer
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			err_count++; \
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
		end \
	end
module psu_signal_sequencer_test;
	localparam int CPM = 4;
	localparam int LIMIT = 90000;
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic LINE_OK_I = 1'b0;
	logic EN_N;
	logic KILL;
	logic WANT_ON = 1'b0;
	logic SEATED = 1'b1;
	logic IDLE_STANDBY_PERMIT_I = 1'b0;
	logic LIGHT_LOAD_I = 1'b0;
	logic MAIN_REG_OK_I = 1'b1;
	logic STBY_REG_OK_I = 1'b1;
	logic OT_SHUT_I = 1'b0;
	logic OT_WARN_I = 1'b0;
	logic OV_I = 1'b0;
	logic OC_I = 1'b0;
	logic [6:0] FAN_ERR_PCT_I = 7'h00;
	logic [3:0] ADDR_I = 4'h0;
	logic [31:0] WDATA_I = 32'h0;
	logic WE_I = 1'b0;
	logic RE_I = 1'b0;
	logic [31:0] RDATA_O;
	logic STBY_RAIL_EN_O;
	logic MAIN_RAIL_EN_O;
	logic LINE_GOOD_O;
	logic LINE_LED_O;
	logic DC_GREEN_O;
	logic DC_YELLOW_O;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	int m;
	logic [31:0] rd;
	always #5 CLK_I = ~CLK_I;
	psu_signal_sequencer #(.CYC_PER_MS(CPM), .BLINK_MS(2)) psu_signal_sequencer_inst (
		.CLK_I(CLK_I), .RST_I(RST_I), .LINE_OK_I(LINE_OK_I),
		.MAIN_OUTPUT_ENABLE_N_I(EN_N), .HOT_UNPLUG_KILL_I(KILL),
		.IDLE_STANDBY_PERMIT_I(IDLE_STANDBY_PERMIT_I), .LIGHT_LOAD_I(LIGHT_LOAD_I),
		.MAIN_REG_OK_I(MAIN_REG_OK_I), .STBY_REG_OK_I(STBY_REG_OK_I),
		.OT_SHUT_I(OT_SHUT_I), .OT_WARN_I(OT_WARN_I), .OV_I(OV_I), .OC_I(OC_I),
		.FAN_ERR_PCT_I(FAN_ERR_PCT_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .STBY_RAIL_EN_O(STBY_RAIL_EN_O),
		.MAIN_RAIL_EN_O(MAIN_RAIL_EN_O), .LINE_GOOD_O(LINE_GOOD_O),
		.LINE_LED_O(LINE_LED_O), .DC_GREEN_O(DC_GREEN_O), .DC_YELLOW_O(DC_YELLOW_O));
	psu_host_model #(.MIN_HIGH_CYC(10 * CPM + 4)) psu_host_model_inst (
		.clk_i(CLK_I), .rst_i(RST_I), .want_on_i(WANT_ON), .seated_i(SEATED),
		.enable_n_o(EN_N), .kill_o(KILL), .inserted_o());
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		WE_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge CLK_I);
		WE_I <= 1'b0;
	endtask
	task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge CLK_I);
		RE_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CLK_I);
		RE_I <= 1'b0;
		#1;
		d = RDATA_O;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return STBY_RAIL_EN_O;
			1: return MAIN_RAIL_EN_O;
			2: return LINE_GOOD_O;
			default: return LINE_LED_O;
		endcase
	endfunction
	// Counts edges until the output reaches the level, bounded
	task automatic wait_sig(input int w, input logic v, input int lim, output int c);
		c = 0;
		#1;
		while (sig(w) !== v && c < lim) begin
			@(posedge CLK_I);
			#1;
			c++;
		end
	endtask
	// One window is a whole 6-slot blink cycle, so counts are exact
	task automatic led(input string what, input int ey, input int eg);
		int y;
		int g;
		y = 0;
		g = 0;
		repeat (12) @(posedge CLK_I);
		repeat (12 * CPM) begin
			@(posedge CLK_I);
			#1;
			y += int'(DC_YELLOW_O === 1'b1);
			g += int'(DC_GREEN_O === 1'b1);
		end
		`CHECK(what, ey, y)
		`CHECK(what, eg, g)
		$display("test %s done", what);
		@(posedge CLK_I);
	endtask
	task automatic setf(input int k, input logic on);
		@(posedge CLK_I);
		case (k)
			0: FAN_ERR_PCT_I <= on ? 7'h14 : 7'h00;
			1: MAIN_REG_OK_I <= ~on;
			2: STBY_REG_OK_I <= ~on;
			default: OT_SHUT_I <= on;
		endcase
	endtask
	initial begin
		repeat (8) @(posedge CLK_I);
		RST_I <= 1'b0;
		rdreg(psu_seq_pkg::CTRL_OFS, rd);
		`CHECK("ctrl_reset", 32'h0, rd)
		wr(4'hC, 32'hFFFFFFFF);
		rdreg(4'hC, rd);
		`CHECK("unmapped", 32'h0, rd)
		@(posedge CLK_I);
		LINE_OK_I <= 1'b1;
		WANT_ON <= 1'b1;
		wait_sig(0, 1'b1, 20 * CPM, n);
		`CHECK("stby_up", 1'b1, STBY_RAIL_EN_O)
		wait_sig(1, 1'b1, 600 * CPM, m);
		`CHECK("stby_to_main", 1'b1, m >= 10 * CPM && m <= 500 * CPM)
		wait_sig(2, 1'b1, 2100 * CPM, n);
		`CHECK("lg_start", 1'b1, n + m <= 2000 * CPM && LINE_GOOD_O === 1'b1)
		`CHECK("line_led", 1'b1, LINE_LED_O)
		rdreg(psu_seq_pkg::STAT_OFS, rd);
		`CHECK("status", 11'h127, rd[10:0])
		led("healthy", 0, 12 * CPM);
		@(posedge CLK_I);
		LINE_OK_I <= 1'b0;
		@(posedge CLK_I);
		LINE_OK_I <= 1'b1;
		wait_sig(2, 1'b0, 10 * CPM, n);
		`CHECK("lg_dip_off", 1'b1, n <= 5 * CPM)
		wait_sig(2, 1'b1, 200 * CPM, n);
		`CHECK("lg_dip_on", 1'b1, n <= 100 * CPM)
		@(posedge CLK_I);
		SEATED <= 1'b0;
		wait_sig(1, 1'b0, 10, n);
		`CHECK("kill_main", 1'b0, MAIN_RAIL_EN_O)
		@(posedge CLK_I);
		SEATED <= 1'b1;
		wait_sig(1, 1'b1, 1300 * CPM, n);
		`CHECK("off_time", 1'b1, n >= 1000 * CPM - 2 && n <= 1200 * CPM)
		`CHECK("kill_stby", 1'b1, STBY_RAIL_EN_O)
		@(posedge CLK_I);
		WANT_ON <= 1'b0;
		OT_WARN_I <= 1'b1;
		@(posedge CLK_I);
		wait_sig(1, 1'b0, 30 * CPM, n);
		`CHECK("en_off", 1'b1, n >= 2 * CPM && n <= 20 * CPM)
		led("enable_high", 6 * CPM, 0);
		OT_WARN_I <= 1'b0;
		WANT_ON <= 1'b1;
		wait_sig(1, 1'b1, 1300 * CPM, n);
		`CHECK("en_on", 1'b1, MAIN_RAIL_EN_O)
		for (int k = 0; k < 4; k++) begin
			setf(k, 1'b1);
			led("solid_fault", 12 * CPM, 0);
			setf(k, 1'b0);
			wait_sig(1, 1'b1, 1300 * CPM, n);
			led("fault_gone", 0, 12 * CPM);
		end
		OT_WARN_I <= 1'b1;
		led("ot_warn", 8 * CPM, 4 * CPM);
		FAN_ERR_PCT_I <= 7'h0A;
		led("warn_over_fan", 8 * CPM, 4 * CPM);
		OT_WARN_I <= 1'b0;
		led("fan_minor", 6 * CPM, 6 * CPM);
		FAN_ERR_PCT_I <= 7'h0F;
		led("fan_edge", 0, 12 * CPM);
		FAN_ERR_PCT_I <= 7'h00;
		OV_I <= 1'b1;
		OC_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		OV_I <= 1'b0;
		OC_I <= 1'b0;
		led("latched", 12 * CPM, 0);
		rdreg(psu_seq_pkg::STAT_OFS, rd);
		`CHECK("latch_set", 1'b1, rd[psu_seq_pkg::ST_LATCH_BIT])
		@(posedge CLK_I);
		WANT_ON <= 1'b0;
		repeat (14 * CPM) @(posedge CLK_I);
		WANT_ON <= 1'b1;
		wait_sig(1, 1'b1, 1300 * CPM, n);
		rdreg(psu_seq_pkg::STAT_OFS, rd);
		`CHECK("latch_clear", 2'h1, {rd[psu_seq_pkg::ST_LATCH_BIT], MAIN_RAIL_EN_O})
		wr(psu_seq_pkg::CTRL_OFS, 32'h1);
		IDLE_STANDBY_PERMIT_I <= 1'b1;
		LIGHT_LOAD_I <= 1'b1;
		rdreg(psu_seq_pkg::CTRL_OFS, rd);
		`CHECK("ctrl_wr", 32'h1, rd)
		wait_sig(1, 1'b0, 30 * CPM, n);
		rdreg(psu_seq_pkg::STAT_OFS, rd);
		`CHECK("idle_stat", 4'hB, {rd[psu_seq_pkg::ST_IDLE_BIT], rd[10:8]})
		led("idle", 4 * CPM, 8 * CPM);
		IDLE_STANDBY_PERMIT_I <= 1'b0;
		LIGHT_LOAD_I <= 1'b0;
		wait_sig(1, 1'b1, 1300 * CPM, n);
		wait_sig(2, 1'b1, 200 * CPM, n);
		@(posedge CLK_I);
		LINE_OK_I <= 1'b0;
		wait_sig(2, 1'b0, 10 * CPM, n);
		`CHECK("lg_loss", 1'b1, n <= 5 * CPM)
		wait_sig(3, 1'b0, 10, n);
		`CHECK("line_led_off", 1'b0, LINE_LED_O)
		wait_sig(1, 1'b0, 100 * CPM, m);
		`CHECK("lg_to_main", 1'b1, m + n >= 7 * CPM)
		wait_sig(0, 1'b0, 100 * CPM, n);
		`CHECK("lg_to_stby", 1'b1, m + n >= 15 * CPM && !STBY_RAIL_EN_O)
		print_verdict();
	end
endmodule
